//--- core/turb_pkg.sv
package turb_pkg;
    localparam int unsigned TURB_CLK_HZ = 250_000_000;
    localparam int unsigned TURB_IDLE_TIME_MS = 20;
    localparam int unsigned TURB_IDLE_CYC =
        (TURB_CLK_HZ / 1000) * TURB_IDLE_TIME_MS;
    localparam int unsigned TURB_IDLE_W = 23;
    localparam int unsigned TURB_BAUD = 115200;
    localparam logic [15:0] TURB_BAUD_DIV_RST = 16'(TURB_CLK_HZ / TURB_BAUD);
    localparam int unsigned TURB_BUF_BYTES = 1015;
    localparam int unsigned TURB_CNT_W = 10;
    localparam logic [9:0] TURB_BUF_LAST = 10'(TURB_BUF_BYTES - 1);
    localparam logic [7:0] TURB_PAYLOAD_MAX = 8'd243;
    localparam logic [7:0] TURB_MTU_MAX = 8'd247;
    localparam logic [7:0] TURB_ATT_HDR = 8'(TURB_MTU_MAX - TURB_PAYLOAD_MAX);
    localparam logic [7:0] TURB_PAYLOAD_DEF = 8'd19;
    localparam logic [19:0] TURB_PASSKEY_RST = 20'h1e0f3;
    localparam logic [3:0] TURB_SEC_RST = 4'h1;
    localparam logic [7:0] TURB_ADV_RST = 8'h01;
    localparam int unsigned TURB_ADV_TXPWR_BIT = 0;
    // security modes offered by a central
    localparam logic [1:0] TURB_SEC_STATIC = 2'h0;
    localparam logic [1:0] TURB_SEC_JUSTWORKS = 2'h1;
    localparam logic [1:0] TURB_SEC_LESC_NUMCMP = 2'h2;
    localparam logic [1:0] TURB_SEC_LESC_PASSKEY = 2'h3;
    // register byte offsets
    localparam logic [7:0] TURB_REG_STATUS = 8'h00;
    localparam logic [7:0] TURB_REG_BAUD = 8'h04;
    localparam logic [7:0] TURB_REG_PASSKEY = 8'h08;
    localparam logic [7:0] TURB_REG_SEC = 8'h0c;
    localparam logic [7:0] TURB_REG_ADV = 8'h10;
    localparam logic [7:0] TURB_REG_NAME_HI = 8'h14;
    localparam logic [7:0] TURB_REG_NAME_LO = 8'h18;
    localparam logic [7:0] TURB_NAME_PREFIX = 8'h41;
    localparam logic [7:0] TURB_NAME_DASH = 8'h2d;
    localparam logic [7:0] TURB_ASCII_0 = 8'h30;
    localparam logic [7:0] TURB_ASCII_A = 8'h37;
    localparam logic [3:0] TURB_DEC_LIM = 4'h9;
    localparam int unsigned TURB_NAME_DIGITS = 6;

    typedef enum logic [1:0] {
        TURB_ST_COLLECT,
        TURB_ST_WAIT_EVT,
        TURB_ST_SEND
    } turb_state_t;
endpackage

//--- core/turb_uart.sv
module turb_uart
    import turb_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic enable_in,
    input wire logic [15:0] baud_div_in,
    input wire logic rxd_in,
    output logic txd_out,
    output logic rx_valid_out,
    output logic [7:0] rx_data_out,
    input wire logic tx_start_in,
    input wire logic [7:0] tx_data_in,
    output logic tx_busy_out
);
    typedef struct packed {
        logic rx_act;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [8:0] rx_sh;
        logic rx_valid;
        logic [7:0] rx_data;
        logic tx_act;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic txd;
    } turb_uart_s_t;

    turb_uart_s_t r, next_r;

    // 8n1: start, eight data bits lsb first, one stop
    always_comb begin
        next_r = r;
        next_r.rx_valid = 1'b0;
        if (!enable_in) begin
            next_r.rx_act = 1'b0;
            next_r.tx_act = 1'b0;
            next_r.txd = 1'b1;
        end else begin
            if (!r.rx_act) begin
                if (!rxd_in) begin
                    next_r.rx_act = 1'b1;
                    next_r.rx_cnt = baud_div_in >> 1;
                    next_r.rx_bit = 4'h0;
                end
            end else if (r.rx_cnt != 16'h0000) begin
                next_r.rx_cnt = r.rx_cnt - 16'h0001;
            end else begin
                next_r.rx_cnt = baud_div_in - 16'h0001;
                next_r.rx_bit = r.rx_bit + 4'h1;
                next_r.rx_sh = {rxd_in, r.rx_sh[8:1]};
                if (r.rx_bit == 4'h0 && rxd_in) begin
                    next_r.rx_act = 1'b0;
                end else if (r.rx_bit == 4'h9) begin
                    next_r.rx_act = 1'b0;
                    // a broken stop bit drops the byte
                    next_r.rx_valid = rxd_in;
                    next_r.rx_data = r.rx_sh[8:1];
                end
            end
            if (!r.tx_act) begin
                next_r.txd = 1'b1;
                if (tx_start_in) begin
                    next_r.tx_act = 1'b1;
                    next_r.tx_sh = {1'b1, tx_data_in, 1'b0};
                    next_r.tx_cnt = baud_div_in - 16'h0001;
                    next_r.tx_bit = 4'h0;
                    next_r.txd = 1'b0;
                end
            end else if (r.tx_cnt != 16'h0000) begin
                next_r.tx_cnt = r.tx_cnt - 16'h0001;
            end else begin
                next_r.tx_cnt = baud_div_in - 16'h0001;
                next_r.tx_bit = r.tx_bit + 4'h1;
                next_r.tx_sh = {1'b1, r.tx_sh[9:1]};
                next_r.txd = r.tx_sh[1];
                if (r.tx_bit == 4'h9) begin
                    next_r.tx_act = 1'b0;
                    next_r.txd = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r <= '0;
            r.txd <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign txd_out = r.txd;
    assign rx_valid_out = r.rx_valid;
    assign rx_data_out = r.rx_data;
    assign tx_busy_out = r.tx_act;
endmodule

//--- core/turb_bridge.sv
module turb_bridge
    import turb_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = TURB_IDLE_CYC
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic mode_strap_in,
    input wire logic [47:0] factory_radio_address_in,
    input wire logic conn_open_in,
    input wire logic conn_event_in,
    input wire logic mtu_valid_in,
    input wire logic [7:0] mtu_in,
    input wire logic pair_req_in,
    input wire logic [1:0] pair_mode_in,
    output logic pair_accept_out,
    output logic pair_reject_out,
    output logic [19:0] pair_code_out,
    output logic channel_open_indicator_out,
    output logic uart_enable_out,
    output logic advertise_out,
    output logic adv_txpower_out,
    output logic transparent_mode_out,
    output logic busy_out,
    input wire logic uart_rxd_in,
    output logic uart_txd_out,
    output logic radio_tx_valid_out,
    output logic [7:0] radio_tx_data_out,
    output logic radio_tx_last_out,
    input wire logic radio_tx_ready_in,
    input wire logic radio_rx_valid_in,
    input wire logic [7:0] radio_rx_data_in,
    output logic radio_rx_ready_out
);
    typedef struct packed {
        logic strap_done;
        logic transparent;
        logic chan_open;
        logic uart_en;
        logic adv_en;
        logic busy;
        turb_state_t st;
        logic [9:0] count;
        logic [9:0] rd;
        logic [7:0] pkt_left;
        logic [7:0] payload;
        logic [22:0] idle;
        logic tx_valid;
        logic [7:0] tx_data;
        logic tx_last;
        logic [15:0] baud_div;
        logic [19:0] passkey;
        logic [3:0] sec_flags;
        logic [7:0] adv_flags;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic pair_acc;
        logic pair_rej;
        logic u_start;
        logic [7:0] u_data;
        logic rx_ready;
    } turb_bridge_s_t;

    turb_bridge_s_t r, next_r;
    logic [7:0] buf_mem [0:TURB_BUF_BYTES-1];
    logic u_rx_valid;
    logic [7:0] u_rx_data;
    logic u_tx_busy;
    logic buf_we;
    logic [7:0] name_ch [0:TURB_NAME_DIGITS-1];
    logic [63:0] name;
    logic [7:0] pkt_len;
    logic [9:0] remain;

    function automatic logic [7:0] hex_ascii(input logic [3:0] d);
        if (d > TURB_DEC_LIM) begin
            hex_ascii = TURB_ASCII_A + {4'h0, d};
        end else begin
            hex_ascii = TURB_ASCII_0 + {4'h0, d};
        end
    endfunction

    // lower six digits of the address, most significant first
    genvar gi;
    generate
        for (gi = 0; gi < TURB_NAME_DIGITS; gi++) begin : g_name
            assign name_ch[gi] =
                hex_ascii(factory_radio_address_in[23-4*gi -: 4]);
        end
    endgenerate
    assign name = {TURB_NAME_PREFIX, TURB_NAME_DASH, name_ch[0], name_ch[1],
                   name_ch[2], name_ch[3], name_ch[4], name_ch[5]};

    turb_uart u_uart (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .enable_in(r.uart_en),
        .baud_div_in(r.baud_div),
        .rxd_in(uart_rxd_in),
        .txd_out(uart_txd_out),
        .rx_valid_out(u_rx_valid),
        .rx_data_out(u_rx_data),
        .tx_start_in(r.u_start),
        .tx_data_in(r.u_data),
        .tx_busy_out(u_tx_busy)
    );

    // bytes left after the current read pointer
    assign remain = r.count - r.rd;
    assign pkt_len = (remain < {2'b00, r.payload}) ? remain[7:0] : r.payload;
    // busy gate drops bytes rather than stalling the line
    assign buf_we = u_rx_valid && r.uart_en && !r.busy
        && r.st == TURB_ST_COLLECT;

    always_comb begin
        next_r = r;
        next_r.pair_acc = 1'b0;
        next_r.pair_rej = 1'b0;
        next_r.u_start = 1'b0;
        next_r.pslverr = 1'b0;
        next_r.pready = 1'b0;
        if (!r.strap_done) begin
            next_r.strap_done = 1'b1;
            next_r.transparent = mode_strap_in;
        end
        next_r.chan_open = r.transparent && conn_open_in;
        next_r.uart_en = r.transparent && conn_open_in;
        next_r.adv_en = r.transparent && !conn_open_in;

        if (mtu_valid_in && conn_open_in) begin
            if (mtu_in >= TURB_MTU_MAX) begin
                next_r.payload = TURB_PAYLOAD_MAX;
            end else if (mtu_in > TURB_PAYLOAD_DEF + TURB_ATT_HDR) begin
                next_r.payload = mtu_in - TURB_ATT_HDR;
            end
        end

        if (pair_req_in && r.transparent) begin
            if (pair_mode_in == TURB_SEC_LESC_NUMCMP
                || pair_mode_in == TURB_SEC_LESC_PASSKEY) begin
                next_r.pair_rej = 1'b1;
            end else if (r.sec_flags[pair_mode_in]) begin
                next_r.pair_acc = 1'b1;
            end else begin
                next_r.pair_rej = 1'b1;
            end
        end

        // radio bytes go out on the uart as received
        if (radio_rx_valid_in && r.rx_ready) begin
            next_r.u_start = 1'b1;
            next_r.u_data = radio_rx_data_in;
        end

        if (r.tx_valid && radio_tx_ready_in) begin
            next_r.tx_valid = 1'b0;
        end

        case (r.st)
            TURB_ST_COLLECT: begin
                next_r.busy = 1'b0;
                if (buf_we) begin
                    next_r.count = r.count + 10'h001;
                    next_r.idle = '0;
                    if (r.count == TURB_BUF_LAST) begin
                        next_r.busy = 1'b1;
                        next_r.st = TURB_ST_WAIT_EVT;
                    end
                end else if (r.count != '0) begin
                    next_r.idle = r.idle + 23'h000001;
                    if (r.idle == 23'(IDLE_CYCLES - 1)) begin
                        next_r.busy = 1'b1;
                        next_r.st = TURB_ST_WAIT_EVT;
                    end
                end
            end
            TURB_ST_WAIT_EVT: begin
                if (conn_event_in) begin
                    next_r.pkt_left = pkt_len;
                    next_r.st = TURB_ST_SEND;
                end
            end
            TURB_ST_SEND: begin
                if (!r.tx_valid || radio_tx_ready_in) begin
                    if (r.pkt_left != 8'h00) begin
                        next_r.tx_valid = 1'b1;
                        next_r.tx_data = buf_mem[r.rd];
                        next_r.tx_last = (r.pkt_left == 8'h01);
                        next_r.rd = r.rd + 10'h001;
                        next_r.pkt_left = r.pkt_left - 8'h01;
                    end else if (r.rd == r.count) begin
                        next_r.busy = 1'b0;
                        next_r.count = '0;
                        next_r.rd = '0;
                        next_r.idle = '0;
                        next_r.st = TURB_ST_COLLECT;
                    end else begin
                        // one packet per interval: wait for next event
                        next_r.st = TURB_ST_WAIT_EVT;
                    end
                end
            end
            default: next_r.st = TURB_ST_COLLECT;
        endcase

        // a dropped link loses any unsent data
        if (!conn_open_in) begin
            next_r.st = TURB_ST_COLLECT;
            next_r.busy = 1'b0;
            next_r.count = '0;
            next_r.rd = '0;
            next_r.idle = '0;
            next_r.tx_valid = 1'b0;
            next_r.payload = TURB_PAYLOAD_DEF;
        end

        // uart busy lags its start strobe by one cycle
        next_r.rx_ready = next_r.uart_en && !u_tx_busy
            && !next_r.u_start && !r.u_start;

        // apb: one wait state, answer registered
        if (psel && penable && !r.pready) begin
            next_r.pready = 1'b1;
            next_r.prdata = '0;
            if (paddr == TURB_REG_STATUS) begin
                next_r.prdata = {6'h00, r.count, r.payload, 4'h0,
                                 r.uart_en, r.busy, r.chan_open,
                                 r.transparent};
            end else if (paddr == TURB_REG_BAUD) begin
                next_r.prdata = {16'h0000, r.baud_div};
                if (pwrite) begin
                    next_r.baud_div = pwdata[15:0];
                end
            end else if (paddr == TURB_REG_PASSKEY) begin
                next_r.prdata = {12'h000, r.passkey};
                if (pwrite) begin
                    next_r.passkey = pwdata[19:0];
                end
            end else if (paddr == TURB_REG_SEC) begin
                next_r.prdata = {28'h0000000, r.sec_flags};
                if (pwrite) begin
                    next_r.sec_flags = pwdata[3:0];
                end
            end else if (paddr == TURB_REG_ADV) begin
                next_r.prdata = {24'h000000, r.adv_flags};
                if (pwrite) begin
                    next_r.adv_flags = pwdata[7:0];
                end
            end else if (paddr == TURB_REG_NAME_HI) begin
                next_r.prdata = name[63:32];
            end else if (paddr == TURB_REG_NAME_LO) begin
                next_r.prdata = name[31:0];
            end else begin
                next_r.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r <= '0;
            r.st <= TURB_ST_COLLECT;
            r.payload <= TURB_PAYLOAD_DEF;
            r.baud_div <= TURB_BAUD_DIV_RST;
            r.passkey <= TURB_PASSKEY_RST;
            r.sec_flags <= TURB_SEC_RST;
            r.adv_flags <= TURB_ADV_RST;
        end else begin
            r <= next_r;
        end
    end

    // storage has no reset; only count marks valid bytes
    always_ff @(posedge clk_in) begin
        if (buf_we) begin
            buf_mem[r.count] <= u_rx_data;
        end
    end

    assign pready = r.pready;
    assign prdata = r.prdata;
    assign pslverr = r.pslverr;
    assign pair_accept_out = r.pair_acc;
    assign pair_reject_out = r.pair_rej;
    assign pair_code_out = r.passkey;
    assign channel_open_indicator_out = r.chan_open;
    assign uart_enable_out = r.uart_en;
    assign advertise_out = r.adv_en;
    // tx power block never advertised: tied low in every mode
    assign adv_txpower_out = 1'b0;
    assign transparent_mode_out = r.transparent;
    assign busy_out = r.busy;
    assign radio_tx_valid_out = r.tx_valid;
    assign radio_tx_data_out = r.tx_data;
    assign radio_tx_last_out = r.tx_last;
    assign radio_rx_ready_out = r.rx_ready;
endmodule

//--- dv/turb_checker.sv
module turb_checker (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic conn_open_in,
    input wire logic conn_event_in,
    input wire logic pair_req_in,
    input wire logic [1:0] pair_mode_in,
    input wire logic pair_accept_out,
    input wire logic pair_reject_out,
    input wire logic channel_open_indicator_out,
    input wire logic uart_enable_out,
    input wire logic advertise_out,
    input wire logic adv_txpower_out,
    input wire logic transparent_mode_out,
    input wire logic busy_out,
    input wire logic radio_tx_valid_out,
    input wire logic [7:0] radio_tx_data_out,
    input wire logic radio_tx_last_out,
    input wire logic radio_tx_ready_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pkt_cnt;

    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // bytes already sent in the current packet
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pkt_cnt <= 8'h00;
        end else if (radio_tx_valid_out && radio_tx_ready_in) begin
            pkt_cnt <= radio_tx_last_out ? 8'h00 : pkt_cnt + 8'h01;
        end
    end

    mode_kept_a: assert property (
        $past(transparent_mode_out) |-> transparent_mode_out)
        else $error("transparent mode dropped");
    ind_follow_a: assert property (
        channel_open_indicator_out == ($past(transparent_mode_out)
        && $past(conn_open_in))) else $error("indicator wrong");
    uart_gate_a: assert property (
        uart_enable_out == channel_open_indicator_out)
        else $error("uart enable differs from channel state");
    advert_on_a: assert property (
        advertise_out == ($past(transparent_mode_out)
        && !$past(conn_open_in))) else $error("advertising wrong");
    no_txpower_a: assert property (
        adv_txpower_out == 1'b0) else $error("tx power block present");
    lesc_refused_a: assert property (
        pair_req_in && transparent_mode_out && pair_mode_in[1]
        |=> pair_reject_out && !pair_accept_out)
        else $error("secure mode not refused");
    stream_hold_a: assert property (
        radio_tx_valid_out && !radio_tx_ready_in
        |=> radio_tx_valid_out && $stable(radio_tx_data_out))
        else $error("radio byte changed while stalled");
    pkt_on_event_a: assert property (
        $rose(radio_tx_valid_out) |-> $past(conn_event_in, 2))
        else $error("packet started without interval event");
    tx_while_busy_a: assert property (
        radio_tx_valid_out |-> busy_out)
        else $error("radio transfer while busy low");
    pkt_len_a: assert property (
        radio_tx_valid_out |-> pkt_cnt < 8'hf3)
        else $error("packet longer than largest payload");
endmodule

bind turb_bridge turb_checker u_turb_checker (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .conn_open_in(conn_open_in),
    .conn_event_in(conn_event_in),
    .pair_req_in(pair_req_in),
    .pair_mode_in(pair_mode_in),
    .pair_accept_out(pair_accept_out),
    .pair_reject_out(pair_reject_out),
    .channel_open_indicator_out(channel_open_indicator_out),
    .uart_enable_out(uart_enable_out),
    .advertise_out(advertise_out),
    .adv_txpower_out(adv_txpower_out),
    .transparent_mode_out(transparent_mode_out),
    .busy_out(busy_out),
    .radio_tx_valid_out(radio_tx_valid_out),
    .radio_tx_data_out(radio_tx_data_out),
    .radio_tx_last_out(radio_tx_last_out),
    .radio_tx_ready_in(radio_tx_ready_in)
);

//--- dv/turb_host_model.sv
module turb_host_model (
    input wire logic clk_in,
    input wire logic busy_in,
    input wire logic rxd_in,
    output logic txd_out,
    input wire logic [15:0] bit_cyc_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];

    initial txd_out = 1'b1;

    // ignore_busy only for the deliberate overrun test
    task automatic send_byte(input logic [7:0] b, input logic ignore_busy);
        int i;
        int n;
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        n = 0;
        while (busy_in !== 1'b0 && !ignore_busy && n < 3000) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 3000) turb_bridge_tb_top.to(n, 3000);
        for (i = 0; i < 10; i++) begin
            txd_out <= f[i];
            repeat (bit_cyc_in) @(posedge clk_in);
        end
    endtask

    // sample mid-bit, far from the sender's edges
    always begin
        logic [7:0] v;
        @(negedge rxd_in);
        repeat (bit_cyc_in / 2) @(posedge clk_in);
        for (int j = 0; j < 8; j++) begin
            repeat (bit_cyc_in) @(posedge clk_in);
            v[j] = rxd_in;
        end
        repeat (bit_cyc_in) @(posedge clk_in);
        rx_q.push_back(v);
    end
endmodule

//--- dv/turb_bridge_tb_top.sv
module turb_bridge_tb_top
    import turb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IDLE = 200;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, stall = 1'b0, se;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, mtu_in = 8'h00, radio_rx_data_in = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, pair_accept_out, pair_reject_out, uart_rxd_in;
    logic mode_strap_in = 1'b1, conn_open_in = 1'b0, conn_event_in = 1'b0;
    logic mtu_valid_in = 1'b0, pair_req_in = 1'b0, radio_tx_ready_in = 1'b1;
    logic radio_rx_valid_in = 1'b0;
    logic [47:0] factory_radio_address_in = 48'h0000_00ab_c123;
    logic [1:0] pair_mode_in = 2'h0;
    logic [19:0] pair_code_out;
    logic channel_open_indicator_out, uart_enable_out, advertise_out;
    logic adv_txpower_out, transparent_mode_out, busy_out, uart_txd_out;
    logic radio_tx_valid_out, radio_tx_last_out, radio_rx_ready_out;
    logic [7:0] radio_tx_data_out;
    logic [7:0] txq[$], exq[$];
    int pkq[$];
    int errors = 0, tests_run = 0, pc = 0, nw;

    turb_bridge #(.IDLE_CYCLES(IDLE)) u_turb_bridge (.*);
    turb_host_model u_turb_host_model (.clk_in(clk_in), .busy_in(busy_out),
        .rxd_in(uart_txd_out), .txd_out(uart_rxd_in), .bit_cyc_in(16'h0008));

    always #2 clk_in = ~clk_in;
    always @(posedge clk_in)
        radio_tx_ready_in <= stall ? ~radio_tx_ready_in : 1'b1;
    always @(posedge clk_in) begin
        if (radio_tx_valid_out && radio_tx_ready_in) begin
            txq.push_back(radio_tx_data_out);
            pc++;
            if (radio_tx_last_out) begin
                pkq.push_back(pc);
                pc = 0;
            end
        end
    end

    task give_verdict;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task to(input int n, input int lim);
        if (n >= lim) begin
            chk(n, 0);
            give_verdict();
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        to(n, 40);
    endtask
    task wbusy(input int lim);
        nw = 0;
        while (busy_out !== 1'b1 && nw < lim) begin
            @(posedge clk_in);
            nw++;
        end
        to(nw, lim);
    endtask
    // one interval event, then exactly one packet and silence
    task pkt(input int len);
        int n;
        @(posedge clk_in);
        conn_event_in <= 1'b1;
        @(posedge clk_in);
        conn_event_in <= 1'b0;
        n = 0;
        while (pkq.size() == 0 && n < 2000) begin
            @(posedge clk_in);
            n++;
        end
        to(n, 2000);
        chk(pkq.pop_front(), len);
        repeat (30) @(posedge clk_in);
        chk(pkq.size(), 0);
    endtask
    task cmp;
        chk(txq.size(), exq.size());
        while (exq.size() > 0) chk(txq.pop_front(), exq.pop_front());
        txq.delete();
    endtask
    task pair(input logic [1:0] m);
        @(posedge clk_in);
        pair_req_in <= 1'b1;
        pair_mode_in <= m;
        @(posedge clk_in);
        pair_req_in <= 1'b0;
        @(posedge clk_in);
        chk({pair_accept_out, pair_reject_out},
            (m == 2'h0) ? 2'h2 : 2'h1);
    endtask
    // released data bus shows the inverse, not a stale byte
    task rrx(input logic [7:0] b);
        int n;
        @(posedge clk_in);
        radio_rx_valid_in <= 1'b1;
        radio_rx_data_in <= b;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (radio_rx_ready_out !== 1'b1 && n < 5000);
        radio_rx_valid_in <= 1'b0;
        radio_rx_data_in <= ~b;
        to(n, 5000);
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        apb(0, TURB_REG_BAUD, 0);
        chk(rd, {16'h0, TURB_BAUD_DIV_RST});
        apb(0, TURB_REG_PASSKEY, 0);
        chk(rd, 32'h0001e0f3);
        chk({12'h0, pair_code_out}, 32'h0001e0f3);
        apb(0, TURB_REG_STATUS, 0);
        chk(rd[3:0], 4'h1);
        chk({advertise_out, adv_txpower_out}, 2'h2);
        apb(0, TURB_REG_NAME_HI, 0);
        chk(rd === 32'h412d4142 || {<<8{rd}} === 32'h412d4142, 1'b1);
        apb(0, TURB_REG_NAME_LO, 0);
        chk(rd === 32'h43313233 || {<<8{rd}} === 32'h43313233, 1'b1);
        apb(0, 8'h40, 0);
        chk(se, 1'b1);
        chk(rd, 32'h0);
        apb(1, TURB_REG_BAUD, 32'h8);
        $display("test registers done");
        conn_open_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk({channel_open_indicator_out, uart_enable_out}, 2'h3);
        chk({advertise_out, busy_out}, 2'h0);
        for (int m = 0; m < 4; m++) pair(2'(m));
        $display("test connect done");
        stall <= 1'b1;
        for (int i = 0; i < 25; i++) begin
            exq.push_back(8'(i * 7 + 3));
            u_turb_host_model.send_byte(8'(i * 7 + 3), 1'b0);
        end
        wbusy(400);
        chk(nw >= 170 && nw <= 210, 1'b1);
        pkt(19);
        pkt(6);
        chk(busy_out, 1'b0);
        cmp();
        $display("test idle flush done");
        apb(0, TURB_REG_STATUS, 0);
        chk(rd[15:8], TURB_PAYLOAD_DEF);
        @(posedge clk_in);
        mtu_valid_in <= 1'b1;
        mtu_in <= TURB_MTU_MAX;
        @(posedge clk_in);
        mtu_valid_in <= 1'b0;
        stall <= 1'b0;
        apb(0, TURB_REG_STATUS, 0);
        chk(rd[15:8], TURB_PAYLOAD_MAX);
        for (int i = 0; i < 1015; i++) begin
            exq.push_back(8'(i));
            u_turb_host_model.send_byte(8'(i), 1'b0);
        end
        wbusy(20);
        apb(0, TURB_REG_STATUS, 0);
        chk({rd[25:16], rd[2]}, {10'h3f7, 1'b1});
        u_turb_host_model.send_byte(8'hee, 1'b1);
        for (int k = 0; k < 4; k++) pkt(243);
        pkt(43);
        cmp();
        $display("test full buffer done");
        rrx(8'h5a);
        rrx(8'h00);
        rrx(8'hff);
        nw = 0;
        while (u_turb_host_model.rx_q.size() < 3 && nw < 2000) begin
            @(posedge clk_in);
            nw++;
        end
        to(nw, 2000);
        chk(u_turb_host_model.rx_q[0], 8'h5a);
        chk(u_turb_host_model.rx_q[1], 8'h00);
        chk(u_turb_host_model.rx_q[2], 8'hff);
        $display("test radio to uart done");
        conn_open_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk({channel_open_indicator_out, uart_enable_out}, 2'h0);
        chk(advertise_out, 1'b1);
        u_turb_host_model.send_byte(8'h11, 1'b0);
        repeat (IDLE + 50) @(posedge clk_in);
        chk(busy_out, 1'b0);
        apb(0, TURB_REG_STATUS, 0);
        chk({rd[25:16], rd[15:8]}, {10'h0, TURB_PAYLOAD_DEF});
        $display("test disconnect done");
        mode_strap_in <= 1'b0;
        sys_rst_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        apb(0, TURB_REG_STATUS, 0);
        chk({rd[3:0], advertise_out}, 5'h00);
        $display("test normal mode done");
        give_verdict();
    end
endmodule
